// ---- design/fcp_consts.vh ----
/*
  constants for the flash command/status port controller: register map,
  flash command codes, operation codes, status and config bit positions,
  bus cycle timing. assumes a 25 MHz core clock.
*/
`ifndef FCP_CONSTS_VH
`define FCP_CONSTS_VH

// register map, byte addresses
`define FCP_REG_CTRL     8'h00
`define FCP_REG_ADDR     8'h04
`define FCP_REG_WDATA    8'h08
`define FCP_REG_CFG      8'h0C
`define FCP_REG_RESULT   8'h10
`define FCP_REG_STAT     8'h14

// flash command codes
`define FCP_CMD_ARRAY    8'hFF
`define FCP_CMD_IDENT    8'h90
`define FCP_CMD_STATUS   8'h70
`define FCP_CMD_CLEAR    8'h50
`define FCP_CMD_ERASE    8'h20
`define FCP_CMD_CONFIRM  8'hD0
`define FCP_CMD_SUSPEND  8'hB0
`define FCP_CMD_PROG     8'h40
`define FCP_CMD_PROG_ALT 8'h10

// operation codes, ctrl bits 3:0; raw code in ctrl bits 15:8
`define FCP_OP_ARRAY     4'h0
`define FCP_OP_IDENT     4'h1
`define FCP_OP_STATUS    4'h2
`define FCP_OP_CLEAR     4'h3
`define FCP_OP_ERASE     4'h4
`define FCP_OP_SUSPEND   4'h5
`define FCP_OP_RESUME    4'h6
`define FCP_OP_PROG      4'h7
`define FCP_OP_READ      4'h8
`define FCP_OP_RAW       4'h9

// flash status bits
`define FCP_SR_READY     7
`define FCP_SR_SUSP      6
`define FCP_SR_EFAIL     5
`define FCP_SR_PFAIL     4
`define FCP_SR_SUPPLY    3

// config register bits
`define FCP_CFG_BYTE     0
`define FCP_CFG_BOOT     1
`define FCP_CFG_UNLOCK   2
`define FCP_CFG_PWRDN    3
`define FCP_CFG_IDV      4
`define FCP_CFG_W        5

// stat register bits
`define FCP_ST_BUSY      0
`define FCP_ST_DONE      1
`define FCP_ST_REFUSED   2

// data line enables
`define FCP_DQ_OE_WORD   16'hFFFF
`define FCP_DQ_OE_BYTE   16'h80FF
`define FCP_DQ_OE_BRD    16'h8000

// timing
`define FCP_CLK_NS       40
`define FCP_T_SETUP_NS   40
`define FCP_T_WP_NS      50
`define FCP_T_ACC_NS     80
`define FCP_T_HOLD_NS    40
`define FCP_SYNC_CYC     3
`define FCP_T_SETUP_CYC  ((`FCP_T_SETUP_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_T_WP_CYC     ((`FCP_T_WP_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_T_ACC_CYC    ((`FCP_T_ACC_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_T_HOLD_CYC   ((`FCP_T_HOLD_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)

`endif

// ---- design/fcp_bus_cycle.v ----
/*
  one asynchronous flash bus cycle, write or read, with setup, strobe and
  hold phases. assumes a synchronised reset and a 25 MHz clock.
*/
`timescale 1ns/1ns
`include "fcp_consts.vh"
module fcp_bus_cycle (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // request
  input  wire        start_i,
  input  wire        read_i,
  input  wire [18:0] addr_i,
  input  wire [15:0] data_i,
  input  wire        byte_mode_i,
  output reg         done_o,
  output reg  [15:0] rdata_o,
  // flash pins
  input  wire [15:0] dq_i,
  output reg         ce_n_o,
  output reg         we_n_o,
  output reg         oe_n_o,
  output reg  [17:0] addr_o,
  output reg  [15:0] dq_o,
  output reg  [15:0] dq_oe_o
);
  localparam [1:0] C_IDLE  = 2'd0;
  localparam [1:0] C_SETUP = 2'd1;
  localparam [1:0] C_PULSE = 2'd2;
  localparam [1:0] C_HOLD  = 2'd3;
  localparam integer SETUP_N   = `FCP_T_SETUP_CYC;
  localparam integer WP_N      = `FCP_T_WP_CYC;
  localparam integer RD_N      = `FCP_T_ACC_CYC + `FCP_SYNC_CYC;
  localparam integer HOLD_N    = `FCP_T_HOLD_CYC;
  localparam [3:0]   SETUP_CYC = SETUP_N[3:0];
  localparam [3:0]   WP_CYC    = WP_N[3:0];
  localparam [3:0]   RD_CYC    = RD_N[3:0];
  localparam [3:0]   HOLD_CYC  = HOLD_N[3:0];

  reg [1:0]  st_r;
  reg [3:0]  cnt_r;
  reg        rd_r;
  reg        bm_r;
  wire [15:0] dq_mask;

  // lines 7:0 and line 15 in byte mode, or all 16 lines in word mode, take part in the settle test
  assign dq_mask = bm_r ? `FCP_DQ_OE_BYTE : `FCP_DQ_OE_WORD;
  reg [15:0] s1_r;
  reg [15:0] s2_r;
  reg [15:0] s3_r;

  // data line synchroniser
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
    end else begin
      s1_r <= dq_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= C_IDLE;
      cnt_r   <= 4'h0;
      rd_r    <= 1'b0;
      bm_r    <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 16'h0000;
      ce_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      addr_o  <= 18'h00000;
      dq_o    <= 16'h0000;
      dq_oe_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (start_i) begin
            rd_r  <= read_i;
            bm_r  <= byte_mode_i;
            cnt_r <= SETUP_CYC - 4'h1;
            st_r  <= C_SETUP;
            if (byte_mode_i) begin
              addr_o  <= addr_i[18:1];
              dq_o    <= {addr_i[0], 7'h00, data_i[7:0]};
              dq_oe_o <= read_i ? `FCP_DQ_OE_BRD : `FCP_DQ_OE_BYTE;
            end else begin
              addr_o  <= addr_i[17:0];
              dq_o    <= data_i;
              dq_oe_o <= read_i ? 16'h0000 : `FCP_DQ_OE_WORD;
            end
          end
        end
        C_SETUP: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            ce_n_o <= 1'b0;
            we_n_o <= rd_r;
            oe_n_o <= ~rd_r;
            cnt_r  <= rd_r ? RD_CYC - 4'h1 : WP_CYC - 4'h1;
            st_r   <= C_PULSE;
          end
        end
        C_PULSE: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (!rd_r || ((s2_r ^ s3_r) & dq_mask) == 16'h0000) begin
            if (rd_r) begin
              rdata_o <= s3_r;
            end
            ce_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_r  <= HOLD_CYC - 4'h1;
            st_r   <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            dq_oe_o <= 16'h0000;
            done_o  <= 1'b1;
            st_r    <= C_IDLE;
          end
        end
        default: begin
          st_r <= C_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- design/fcp_host.v ----
/*
  host controller for an asynchronous boot-block flash: takes operations
  from a simple register port and runs the command, program, erase and
  status polling sequences on the flash pins. assumes one 25 MHz clock;
  flash pins reach the device directly, dq is joined from dq_o/dq_oe_o.
*/
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "fcp_consts.vh"
module fcp_host (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // flash bus
  output wire        flash_ce_n_o,
  output wire        flash_we_n_o,
  output wire        flash_oe_n_o,
  output wire [17:0] flash_addr_o,
  output wire [15:0] flash_dq_o,
  output wire [15:0] flash_dq_oe_o,
  input  wire [15:0] flash_dq_i,
  // flash control pins
  output reg         flash_byte_n_o,
  output reg         reset_powerdown_n_o,
  output reg         unlock_voltage_o,
  output reg         flash_protect_override_o,
  output reg         program_supply_high_o,
  output reg         id_entry_voltage_o
);
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_LAUNCH = 3'd1;
  localparam [2:0] S_WAIT  = 3'd2;
  localparam [1:0] STEP_A  = 2'd0;
  localparam [1:0] STEP_B  = 2'd1;
  localparam [1:0] STEP_P  = 2'd2;

  reg                 rs1_r;
  reg                 rst_n_r;
  reg [2:0]           st_r;
  reg [1:0]           step_r;
  reg [3:0]           op_r;
  reg [7:0]           raw_r;
  reg [18:0]          addr_r;
  reg [15:0]          wdata_r;
  reg [`FCP_CFG_W-1:0] cfg_r;
  reg [15:0]          result_r;
  reg [7:0]           fstat_r;
  reg                 busy_r;
  reg                 done_r;
  reg                 refused_r;
  reg                 cyc_start_r;
  reg                 cyc_read;
  reg [18:0]          cyc_addr;
  reg [15:0]          cyc_data;
  wire                cyc_done;
  wire [15:0]         cyc_rdata;
  wire                ctrl_wr;
  wire                op_ok;

  // listed command codes only
  function cmd_ok;
    input [7:0] c;
    begin
      case (c)
        `FCP_CMD_ARRAY, `FCP_CMD_IDENT, `FCP_CMD_STATUS, `FCP_CMD_CLEAR,
        `FCP_CMD_ERASE, `FCP_CMD_CONFIRM, `FCP_CMD_SUSPEND,
        `FCP_CMD_PROG, `FCP_CMD_PROG_ALT: cmd_ok = 1'b1;
        default: cmd_ok = 1'b0;
      endcase
    end
  endfunction

  // operations that end by polling until ready
  function needs_poll;
    input [3:0] op;
    begin
      needs_poll = (op == `FCP_OP_ERASE) || (op == `FCP_OP_SUSPEND) ||
                   (op == `FCP_OP_RESUME) || (op == `FCP_OP_PROG);
    end
  endfunction

  // operations that run the program/erase engine
  function needs_supply;
    input [3:0] op;
    begin
      needs_supply = (op == `FCP_OP_ERASE) || (op == `FCP_OP_RESUME) ||
                     (op == `FCP_OP_PROG);
    end
  endfunction

  // operations with a second bus cycle
  function has_second;
    input [3:0] op;
    begin
      has_second = (op == `FCP_OP_IDENT) || (op == `FCP_OP_STATUS) ||
                   (op == `FCP_OP_ERASE) || (op == `FCP_OP_PROG);
    end
  endfunction

  // reset release
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs1_r   <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rs1_r   <= 1'b1;
      rst_n_r <= rs1_r;
    end
  end

  assign ctrl_wr = reg_wr_i && (reg_addr_i == `FCP_REG_CTRL);
  assign op_ok   = (reg_wdata_i[3:0] <= `FCP_OP_RAW) &&
                   ((reg_wdata_i[3:0] != `FCP_OP_RAW) || cmd_ok(reg_wdata_i[15:8])) &&
                   (!needs_supply(reg_wdata_i[3:0]) || !fstat_r[`FCP_SR_SUPPLY]);

  // cycle contents per operation and step
  always @* begin
    cyc_read = 1'b0;
    cyc_addr = addr_r;
    cyc_data = 16'h0000;
    if (step_r == STEP_P) begin
      cyc_read = 1'b1;
    end else if (step_r == STEP_B) begin
      case (op_r)
        `FCP_OP_ERASE: cyc_data = {8'h00, `FCP_CMD_CONFIRM};
        `FCP_OP_PROG:  cyc_data = wdata_r;
        default:       cyc_read = 1'b1;
      endcase
    end else begin
      case (op_r)
        `FCP_OP_ARRAY:   cyc_data = {8'h00, `FCP_CMD_ARRAY};
        `FCP_OP_IDENT:   cyc_data = {8'h00, `FCP_CMD_IDENT};
        `FCP_OP_STATUS:  cyc_data = {8'h00, `FCP_CMD_STATUS};
        `FCP_OP_CLEAR:   cyc_data = {8'h00, `FCP_CMD_CLEAR};
        `FCP_OP_ERASE:   cyc_data = {8'h00, `FCP_CMD_ERASE};
        `FCP_OP_SUSPEND: cyc_data = {8'h00, `FCP_CMD_SUSPEND};
        `FCP_OP_RESUME:  cyc_data = {8'h00, `FCP_CMD_CONFIRM};
        `FCP_OP_PROG:    cyc_data = {8'h00, `FCP_CMD_PROG};
        `FCP_OP_READ:    cyc_read = 1'b1;
        default:         cyc_data = {8'h00, raw_r};
      endcase
    end
  end

  // registers and sequencer
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r        <= S_IDLE;
      step_r      <= STEP_A;
      op_r        <= `FCP_OP_ARRAY;
      raw_r       <= 8'h00;
      addr_r      <= 19'h00000;
      wdata_r     <= 16'h0000;
      cfg_r       <= {`FCP_CFG_W{1'b0}};
      result_r    <= 16'h0000;
      fstat_r     <= 8'h00;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      refused_r   <= 1'b0;
      cyc_start_r <= 1'b0;
    end else begin
      cyc_start_r <= 1'b0;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `FCP_REG_ADDR:  addr_r  <= reg_wdata_i[18:0];
          `FCP_REG_WDATA: wdata_r <= reg_wdata_i[15:0];
          `FCP_REG_CFG:   cfg_r   <= reg_wdata_i[`FCP_CFG_W-1:0];
          default: ;
        endcase
      end
      if (ctrl_wr && (busy_r || !op_ok)) begin
        refused_r <= 1'b1;
      end
      case (st_r)
        S_IDLE: begin
          if (ctrl_wr && op_ok) begin
            op_r      <= reg_wdata_i[3:0];
            raw_r     <= reg_wdata_i[15:8];
            busy_r    <= 1'b1;
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            if (reg_wdata_i[3:0] == `FCP_OP_CLEAR) begin
              fstat_r[`FCP_SR_EFAIL:`FCP_SR_SUPPLY] <= 3'h0;
            end
            step_r    <= STEP_A;
            st_r      <= S_LAUNCH;
          end
        end
        S_LAUNCH: begin
          cyc_start_r <= 1'b1;
          st_r        <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (cyc_read) begin
              result_r <= cyc_rdata;
            end
            if (step_r == STEP_P || (step_r == STEP_B && op_r == `FCP_OP_STATUS)) begin
              fstat_r <= cyc_rdata[7:0];
            end
            if (step_r == STEP_A && has_second(op_r)) begin
              step_r <= STEP_B;
              st_r   <= S_LAUNCH;
            end else if (step_r != STEP_P && needs_poll(op_r)) begin
              step_r <= STEP_P;
              st_r   <= S_LAUNCH;
            end else if (step_r == STEP_P && !cyc_rdata[`FCP_SR_READY]) begin
              st_r <= S_LAUNCH;
            end else begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
              st_r   <= S_IDLE;
            end
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // pin levels and read data
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flash_byte_n_o           <= 1'b1;
      reset_powerdown_n_o      <= 1'b0;
      unlock_voltage_o         <= 1'b0;
      flash_protect_override_o <= 1'b0;
      program_supply_high_o    <= 1'b0;
      id_entry_voltage_o       <= 1'b0;
      reg_rdata_o              <= 32'h00000000;
    end else begin
      flash_byte_n_o      <= ~cfg_r[`FCP_CFG_BYTE];
      reset_powerdown_n_o <= ~cfg_r[`FCP_CFG_PWRDN];
      id_entry_voltage_o  <= cfg_r[`FCP_CFG_IDV];
      program_supply_high_o <= busy_r && needs_supply(op_r);
      unlock_voltage_o <= busy_r && needs_supply(op_r) &&
                          cfg_r[`FCP_CFG_BOOT] && cfg_r[`FCP_CFG_UNLOCK];
      flash_protect_override_o <= busy_r && needs_supply(op_r) &&
                                  cfg_r[`FCP_CFG_BOOT] && !cfg_r[`FCP_CFG_UNLOCK];
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `FCP_REG_ADDR:   reg_rdata_o <= {13'h0000, addr_r};
          `FCP_REG_WDATA:  reg_rdata_o <= {16'h0000, wdata_r};
          `FCP_REG_CFG:    reg_rdata_o <= {27'h0000000, cfg_r};
          `FCP_REG_RESULT: reg_rdata_o <= {16'h0000, result_r};
          `FCP_REG_STAT:   reg_rdata_o <= {16'h0000, fstat_r, 5'h00,
                                           refused_r, done_r, busy_r};
          default:         reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  fcp_bus_cycle u_cycle (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n_r),
    .start_i     (cyc_start_r),
    .read_i      (cyc_read),
    .addr_i      (cyc_addr),
    .data_i      (cyc_data),
    .byte_mode_i (cfg_r[`FCP_CFG_BYTE]),
    .done_o      (cyc_done),
    .rdata_o     (cyc_rdata),
    .dq_i        (flash_dq_i),
    .ce_n_o      (flash_ce_n_o),
    .we_n_o      (flash_we_n_o),
    .oe_n_o      (flash_oe_n_o),
    .addr_o      (flash_addr_o),
    .dq_o        (flash_dq_o),
    .dq_oe_o     (flash_dq_oe_o)
  );
endmodule

// ---- bench/fcp_host_checker.sv ----
/* flash pin checker for fcp_host
   bound to every fcp_host, sees its ports only */
`timescale 1ns/1ns
module fcp_host_checker (
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire        flash_ce_n_o,
  input wire        flash_we_n_o,
  input wire        flash_oe_n_o,
  input wire [17:0] flash_addr_o,
  input wire [15:0] flash_dq_o,
  input wire [15:0] flash_dq_oe_o,
  input wire        flash_byte_n_o,
  input wire        unlock_voltage_o,
  input wire        program_supply_high_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_low_s;
    (!flash_we_n_o && !flash_ce_n_o) [*2];
  endsequence
  sequence wr_end_s;
    flash_we_n_o && flash_ce_n_o;
  endsequence
  cmd_cycle_a: assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o)
    else $error("write strobe with oe low or ce high");
  read_cycle_a: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_ce_n_o)
    else $error("read strobe with we low or ce high");
  write_pulse_a: assert property ($fell(flash_we_n_o) |-> wr_low_s ##1 wr_end_s)
    else $error("write pulse shape wrong");
  capture_hold_a: assert property ($rose(flash_we_n_o) |-> $stable(flash_dq_o))
    else $error("data moved at strobe rise");
  addr_stable_a: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved under chip select");
  byte_float_a: assert property (!flash_byte_n_o |-> flash_dq_oe_o[14:8] == 7'h00)
    else $error("lines 8 to 14 driven in byte mode");
  byte_lsb_a: assert property (!flash_byte_n_o && !flash_ce_n_o |-> flash_dq_oe_o[15])
    else $error("line 15 not driven in byte mode");
  word_drive_a: assert property (flash_byte_n_o && !flash_we_n_o |-> flash_dq_oe_o == 16'hFFFF)
    else $error("word write not on all lines");
  boot_supply_a: assert property (unlock_voltage_o |-> program_supply_high_o)
    else $error("unlock without program supply");
endmodule

bind fcp_host fcp_host_checker chk_u (.core_clk_i, .rst_n_i, .flash_ce_n_o, .flash_we_n_o,
  .flash_oe_n_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_byte_n_o,
  .unlock_voltage_o, .program_supply_high_o);

// ---- bench/fcp_flash_model.sv ----
/* behavioural boot-block flash: decoder, status byte, id bytes, 16 words
   driven by asynchronous strobes; word 0 stands for the boot block */
`timescale 1ns/1ns
module fcp_flash_model #(
  parameter [7:0] MAKER_CODE = 8'h3C, // arbitrary
  parameter [7:0] PART_CODE  = 8'h5A, // arbitrary
  parameter [7:0] PART_HI    = 8'hA5, // arbitrary
  parameter       PROG_NS    = 2000,
  parameter       ERASE_NS   = 4000
) (
  // strobes, address, data
  input  wire        ce_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire [17:0] addr_i,
  input  wire [15:0] dq_i,
  output reg  [15:0] dq_o,
  output reg  [15:0] dq_oe_o,
  // control pins
  input  wire        byte_n_i,
  input  wire        rp_n_i,
  input  wire        supply_i,
  input  wire        boot_ok_i,
  input  wire        idv_i,
  input  wire        fail_i
);
  localparam ARR = 3'h0, IDM = 3'h1, STM = 3'h2, PSET = 3'h3;
  localparam ESET = 3'h4, PRG = 3'h5, ERS = 3'h6, SUS = 3'h7;
  reg  [2:0]  mode_r;
  reg  [15:0] mem_r [0:15];
  reg         susp_r, ef_r, pf_r, sm_r;
  reg  [7:0]  snap_r;
  reg  [7:0]  c;
  reg  [3:0]  a;
  reg  [15:0] d;
  time        done_t, rem_t;
  integer     i;
  wire        wstb = ce_n_i | we_n_i;
  wire        rstb = ce_n_i | oe_n_i;
  function bit busy_f();
    busy_f = (mode_r == PRG || mode_r == ERS) && $time < done_t;
  endfunction
  task start(input bit er);
    begin
      mode_r = er ? ERS : PRG;
      done_t = $time + (er ? ERASE_NS : PROG_NS);
      if (!supply_i || sm_r) begin
        sm_r = 1'b1;
        done_t = $time;
      end else if ((er || a == 4'h0) && !boot_ok_i && a == 4'h0) begin
        ef_r = er;
        pf_r = !er;
      end else if (fail_i) begin
        ef_r = er;
        pf_r = !er;
      end else if (er) begin
        for (i = 0; i < 16; i = i + 1) if ((i == 0) == (a == 4'h0)) mem_r[i] = 16'hFFFF;
      end else mem_r[a] = mem_r[a] & d;
    end
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1) mem_r[i] = 16'hFFFF;
    {mode_r, susp_r, ef_r, pf_r, sm_r, snap_r, done_t} = 0;
  end
  always @(negedge rp_n_i) {mode_r, susp_r, ef_r, pf_r, sm_r} = 0;
  always @(negedge rstb) snap_r = {!busy_f(), susp_r, ef_r, pf_r, sm_r, 3'h0};
  always @(posedge wstb) if (oe_n_i && rp_n_i) begin
    a = addr_i[3:0];
    c = dq_i[7:0];
    d = byte_n_i ? dq_i : (dq_i[15] ? {c, 8'hFF} : {8'hFF, c});
    if (busy_f()) begin
      if (mode_r == ERS && c == 8'hB0) begin
        rem_t = done_t - $time;
        susp_r = 1'b1;
        mode_r = SUS;
      end
    end else if (mode_r == PSET) start(1'b0);
    else if (mode_r == ESET) begin
      if (c == 8'hD0) start(1'b1);
      else {ef_r, pf_r, mode_r} = {2'h3, STM};
    end else if (mode_r == SUS && c == 8'hD0) begin
      susp_r = 1'b0;
      mode_r = ERS;
      done_t = $time + rem_t;
    end else if (mode_r != SUS || c == 8'h70 || c == 8'hFF) case (c)
      8'hFF: mode_r = ARR;
      8'h90: mode_r = IDM;
      8'h70: mode_r = STM;
      8'h50: {ef_r, pf_r, sm_r} = 3'h0;
      8'h20: mode_r = ESET;
      8'h40, 8'h10: mode_r = PSET;
      default: ;
    endcase
  end
  always @* begin
    dq_o = mem_r[addr_i[3:0]];
    if (idv_i || mode_r == IDM)
      dq_o = addr_i[0] ? {PART_HI, PART_CODE} : {8'h00, MAKER_CODE};
    else if (mode_r != ARR) dq_o = {8'h00, snap_r};
    dq_oe_o = (!rstb && rp_n_i) ? (byte_n_i ? 16'hFFFF : 16'h00FF) : 16'h0000;
  end
endmodule

// ---- bench/fcp_host_bench.sv ----
/* self-checking bench for fcp_host against fcp_flash_model
   assumes the checker is bound; undriven data lines toggle */
`timescale 1ns/1ns
`include "fcp_consts.vh"
module fcp_host_bench;
  localparam [7:0] MAKER = 8'h3C, PART = 8'h5A, PHI = 8'hA5; // arbitrary
  reg         clk, rst_n, wr, rd, cut, vfor, fail;
  reg  [7:0]  ra;
  reg  [31:0] rw, got, x;
  reg  [15:0] flt;
  reg  [15:0] exp_r [0:15];
  reg  [3:0]  wa;
  wire [31:0] rdat;
  wire        ce_n, we_n, oe_n, byte_n, rp_n, unl, ovr, vpp, idv;
  wire [17:0] fa;
  wire [15:0] hdq, hoe, mdq, moe;
  wire [15:0] dqi = (hoe & hdq) | (moe & mdq) | (~hoe & ~moe & flt);
  integer     bad_count, samples_checked, seed, j, k;
  fcp_host dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(rw),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .flash_ce_n_o(ce_n),
    .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_addr_o(fa), .flash_dq_o(hdq),
    .flash_dq_oe_o(hoe), .flash_dq_i(dqi), .flash_byte_n_o(byte_n), .reset_powerdown_n_o(rp_n),
    .unlock_voltage_o(unl), .flash_protect_override_o(ovr), .program_supply_high_o(vpp),
    .id_entry_voltage_o(idv));
  fcp_flash_model fm_u (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa), .dq_i(dqi),
    .dq_o(mdq), .dq_oe_o(moe), .byte_n_i(byte_n), .rp_n_i(rp_n), .supply_i((vpp | vfor) & ~cut),
    .boot_ok_i(unl | ovr), .idv_i(idv), .fail_i(fail));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt;
  function [15:0] id_f(input bit a0);
    id_f = a0 ? {PHI, PART} : {8'h00, MAKER};
  endfunction
  function [7:0] sr_f(input [4:0] f);
    sr_f = {f, 3'h0};
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task ww(input [7:0] a, input [31:0] v);
    begin
      ra <= a;
      rw <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rr(input [7:0] a, output [31:0] v);
    begin
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdat;
      @(posedge clk);
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cmp_st(input [7:0] e);
    begin
      rr(`FCP_REG_STAT, got);
      cmp({24'h0, got[15:8]}, {24'h0, e});
    end
  endtask
  task op(input [3:0] o, input [7:0] c);
    begin
      ww(`FCP_REG_CTRL, {16'h0, c, 4'h0, o});
      k = 0;
      got = 32'h1;
      while (got[`FCP_ST_BUSY] !== 1'b0 && k < 3000) begin
        rr(`FCP_REG_STAT, got);
        k = k + 1;
      end
      if (k >= 3000) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0t operation hung", $time);
        give_verdict;
      end
    end
  endtask
  task res(input [3:0] o, input [17:0] a, input [15:0] e, input [15:0] m);
    begin
      ww(`FCP_REG_ADDR, {14'h0, a});
      op(o, 8'h00);
      rr(`FCP_REG_RESULT, got);
      cmp(got & {16'h0, m}, {16'h0, e & m});
    end
  endtask
  task prog(input [3:0] a, input [15:0] d);
    begin
      ww(`FCP_REG_ADDR, {28'h0, a});
      ww(`FCP_REG_WDATA, {16'h0, d});
      op(`FCP_OP_PROG, 8'h00);
    end
  endtask
  task refused(input [3:0] o, input [7:0] c);
    begin
      op(o, c);
      rr(`FCP_REG_STAT, got);
      cmp(got[`FCP_ST_REFUSED], 1'b1);
    end
  endtask
  initial begin
    seed = 58373;
    {bad_count, samples_checked} = 0;
    for (j = 0; j < 16; j = j + 1) exp_r[j] = 16'hFFFF;
    {rst_n, wr, rd, cut, vfor, fail, ra, rw, flt} = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rr(`FCP_REG_CFG, got);
    cmp(got, 32'h0);
    rr(8'h3C, got);
    cmp(got, 32'h0);
    for (j = 0; j < 2; j = j + 1) res(`FCP_OP_IDENT, j[17:0], id_f(j[0]), 16'hFFFF);
    ww(`FCP_REG_CFG, 32'h1);
    res(`FCP_OP_IDENT, 18'h2, id_f(1'b1), 16'h00FF);
    op(`FCP_OP_ARRAY, 8'h00);
    ww(`FCP_REG_CFG, 32'h10);
    res(`FCP_OP_READ, 18'h1, id_f(1'b1), 16'hFFFF);
    ww(`FCP_REG_CFG, 32'h0);
    res(`FCP_OP_READ, 18'h1, 16'hFFFF, 16'hFFFF);
    for (j = 0; j < 6; j = j + 1) begin
      x = (j < 2) ? (j ? 32'hFF0F : 32'h00FF) : $random(seed);
      wa = (j < 2) ? 4'h5 : {2'h0, x[17:16]} + 4'h1;
      prog(wa, x[15:0]);
      exp_r[wa] = exp_r[wa] & x[15:0];
      cmp_st(sr_f(5'h10));
      op(`FCP_OP_ARRAY, 8'h00);
      res(`FCP_OP_READ, {14'h0, wa}, exp_r[wa], 16'hFFFF);
    end
    fail <= 1'b1;
    prog(4'h6, 16'h0000);
    fail <= 1'b0;
    cmp_st(sr_f(5'h12));
    op(`FCP_OP_STATUS, 8'h00);
    cmp_st(sr_f(5'h12));
    op(`FCP_OP_CLEAR, 8'h00);
    op(`FCP_OP_STATUS, 8'h00);
    cmp_st(sr_f(5'h10));
    cut <= 1'b1;
    prog(4'h6, 16'h0000);
    cut <= 1'b0;
    cmp_st(sr_f(5'h11));
    refused(`FCP_OP_PROG, 8'h00);
    op(`FCP_OP_CLEAR, 8'h00);
    prog(4'h0, 16'h00FF);
    cmp_st(sr_f(5'h12));
    op(`FCP_OP_CLEAR, 8'h00);
    ww(`FCP_REG_CFG, 32'h6);
    prog(4'h0, 16'h00FF);
    cmp_st(sr_f(5'h10));
    ww(`FCP_REG_CFG, 32'h0);
    ww(`FCP_REG_ADDR, 32'h1);
    op(`FCP_OP_ERASE, 8'h00);
    cmp_st(sr_f(5'h10));
    op(`FCP_OP_ARRAY, 8'h00);
    res(`FCP_OP_READ, 18'h5, 16'hFFFF, 16'hFFFF);
    res(`FCP_OP_READ, 18'h0, 16'h00FF, 16'hFFFF);
    prog(4'h5, 16'h1234);
    op(`FCP_OP_RAW, 8'hD0);
    op(`FCP_OP_ARRAY, 8'h00);
    res(`FCP_OP_READ, 18'h5, 16'h1234, 16'hFFFF);
    op(`FCP_OP_RAW, 8'h20);
    op(`FCP_OP_RAW, 8'h70);
    op(`FCP_OP_STATUS, 8'h00);
    cmp_st(sr_f(5'h16));
    op(`FCP_OP_CLEAR, 8'h00);
    vfor <= 1'b1;
    op(`FCP_OP_RAW, 8'h20);
    op(`FCP_OP_RAW, 8'hD0);
    op(`FCP_OP_SUSPEND, 8'h00);
    cmp_st(sr_f(5'h18));
    op(`FCP_OP_RESUME, 8'h00);
    cmp_st(sr_f(5'h10));
    vfor <= 1'b0;
    refused(4'hA, 8'h00);
    refused(`FCP_OP_RAW, 8'h00);
    op(`FCP_OP_RAW, 8'h20);
    op(`FCP_OP_RAW, 8'h70);
    ww(`FCP_REG_CFG, 32'h8);
    ww(`FCP_REG_CFG, 32'h0);
    repeat (4) @(posedge clk);
    res(`FCP_OP_READ, 18'h5, 16'hFFFF, 16'hFFFF);
    op(`FCP_OP_STATUS, 8'h00);
    cmp_st(sr_f(5'h10));
    give_verdict;
  end
endmodule
